/* File: logic/csq_pkg.sv */
package csq_pkg;
	// Clock and timing
	localparam int unsigned CLK_HZ          = 50_000_000;
	localparam int unsigned SAMPLE_HZ       = 250_000;
	localparam int unsigned SAMPLE_CYC      = CLK_HZ / SAMPLE_HZ;
	localparam int unsigned IDLE_STEP_MS    = 200;
	localparam int unsigned TOUCH_PERIOD_MS = 25;
	localparam int unsigned PROX_PERIOD_MS  = 36;
	localparam int unsigned SLEEP_STEP_MS   = 100;
	localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
	localparam int unsigned IDLE_STEP_CYC   = IDLE_STEP_MS * CYC_PER_MS;
	localparam int unsigned TOUCH_CYC       = TOUCH_PERIOD_MS * CYC_PER_MS;
	localparam int unsigned PROX_CYC        = PROX_PERIOD_MS * CYC_PER_MS;
	localparam int unsigned SLEEP_STEP_CYC  = SLEEP_STEP_MS * CYC_PER_MS;
	localparam int unsigned SAMPLES_PER_DEC = 3;
	// Division by three in fixed point: 65535 / 3
	localparam logic [14:0] THIRD_SCALE     = 15'h5555;

	// Register word indices (byte address = index * 4)
	localparam logic [5:0] IDX_POWER_CONTROL = 6'h00;
	localparam logic [5:0] IDX_AMB_COMP_0    = 6'h02;
	localparam logic [5:0] IDX_RESULT_BASE   = 6'h0B;
	localparam logic [5:0] IDX_TRIM_BASE     = 6'h20;
	localparam logic [5:0] IDX_MUX_BASE      = 6'h28;
	localparam logic [5:0] IDX_CAL_EN        = 6'h30;
	localparam logic [5:0] IDX_STATUS        = 6'h31;

	// Field positions
	localparam int unsigned MODE_LSB    = 0;
	localparam int unsigned IDLE_LSB    = 2;
	localparam int unsigned LAST_LSB    = 4;
	localparam int unsigned DEC_LSB     = 8;
	localparam int unsigned SLEEP_LSB   = 12;
	localparam int unsigned POS_LSB     = 0;
	localparam int unsigned NEG_LSB     = 8;

	// Reset values
	localparam logic [15:0] POWER_CONTROL_RST = 16'h0000;
	localparam logic [15:0] AMB_COMP_RST      = 16'h0000;
	localparam logic [15:0] TRIM_RST          = 16'h0000;
	localparam logic [15:0] MUX_RST           = 16'h0000;
	localparam logic [7:0]  CAL_EN_RST        = 8'h00;

	localparam int unsigned NUM_STAGES = 8;

	typedef enum logic [1:0] {
		MODE_FULL     = 2'b00,
		MODE_SHUT_A   = 2'b01,
		MODE_LOW      = 2'b10,
		MODE_SHUT_B   = 2'b11
	} csq_mode_t;

	// Gray order along off -> wait -> convert
	typedef enum logic [1:0] {
		ST_OFF  = 2'b00,
		ST_WAIT = 2'b01,
		ST_CONV = 2'b11
	} csq_state_t;
endpackage

/* File: logic/csq_sequencer.sv */
`timescale 1ns/100ps
module csq_sequencer
	import csq_pkg::*;
#(
	parameter int unsigned IDLE_STEP_CYCLES  = IDLE_STEP_CYC,
	parameter int unsigned TOUCH_CYCLES      = TOUCH_CYC,
	parameter int unsigned PROX_CYCLES       = PROX_CYC,
	parameter int unsigned SLEEP_STEP_CYCLES = SLEEP_STEP_CYC
) (
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	// Avalon-MM slave
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// Converter front end
	input  wire logic        mod_bit,
	output logic             afe_power_on,
	output logic             afe_sample,
	output logic [2:0]       afe_stage,
	output logic [15:0]      afe_mux_cfg,
	output logic [5:0]       positive_offset_trim,
	output logic [5:0]       negative_offset_trim,
	// Calibration and threshold logic
	input  wire logic        touch_active,
	input  wire logic        proximity_active,
	input  wire logic [7:0]  pair_hit_a,
	input  wire logic [7:0]  pair_hit_b,
	output logic [7:0]       pair_report_a,
	output logic [7:0]       pair_report_b,
	output logic [7:0]       stage_calibration_enable,
	output logic             result_valid,
	output logic [2:0]       result_stage,
	output logic [15:0]      result_data,
	output logic             ambient_update
);

	// Register storage
	logic [15:0] power_control_ff;
	logic [15:0] ambient_comp_control_0_ff;
	logic [15:0] trim_ff [NUM_STAGES];
	logic [15:0] mux_ff [NUM_STAGES];
	logic [15:0] stage_result_ff [NUM_STAGES];
	logic [7:0]  cal_en_ff;
	// Bus handshake
	logic        ack_ff;
	logic [31:0] rdata_ff;
	logic [5:0]  widx;
	logic        wr_go;
	logic [15:0] wmask;
	// Sequencer state
	csq_state_t  state_ff;
	csq_state_t  nxt_state;
	logic [2:0]  stage_ff;
	logic [2:0]  last_ff;
	logic [1:0]  dec_ff;
	logic [7:0]  smp_div_ff;
	logic [9:0]  smp_cnt_ff;
	logic [9:0]  ones_cnt_ff;
	logic [31:0] period_ff;
	logic [31:0] hold_ff;
	logic        mod_s1_ff;
	logic        mod_s2_ff;
	logic        res_vld_ff;
	logic [2:0]  res_stage_ff;
	logic [15:0] res_data_ff;
	logic        amb_ff;
	logic [7:0]  rpt_a_ff;
	logic [7:0]  rpt_b_ff;
	// Decoded controls
	csq_mode_t   mode;
	logic        shutdown;
	logic        low_power;
	logic        sample_tick;
	logic [9:0]  samples_needed;
	logic        stage_done;
	logic        seq_done;
	logic [31:0] target_period;
	logic        lp_fast;
	logic [2:0]  last_req;
	logic [24:0] scaled;
	logic [15:0] avg_result;
	logic [31:0] idle_cycles;
	logic [31:0] sleep_cycles;

	assign mode      = csq_mode_t'(power_control_ff[MODE_LSB +: 2]);
	assign shutdown  = power_control_ff[MODE_LSB];
	assign low_power = (mode == MODE_LOW);

	// Bus decode, one wait state per access
	assign widx            = avs_address[7:2];
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
	assign wr_go           = avs_write & ack_ff;
	assign wmask           = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	assign avs_readdata    = rdata_ff;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= (avs_read | avs_write) & ~ack_ff;
		end
	end

	// Read mux, loaded in the wait cycle
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rdata_ff <= 32'h0000_0000;
		end else if (avs_read && !ack_ff) begin
			rdata_ff <= 32'h0000_0000;
			if (widx == IDX_POWER_CONTROL) begin
				rdata_ff[15:0] <= power_control_ff;
			end else if (widx == IDX_AMB_COMP_0) begin
				rdata_ff[15:0] <= ambient_comp_control_0_ff;
			end else if (widx >= IDX_RESULT_BASE && widx < IDX_RESULT_BASE + 6'h08) begin
				rdata_ff[15:0] <= stage_result_ff[3'(widx - IDX_RESULT_BASE)];
			end else if (widx >= IDX_TRIM_BASE && widx < IDX_TRIM_BASE + 6'h08) begin
				rdata_ff[15:0] <= trim_ff[widx[2:0]];
			end else if (widx >= IDX_MUX_BASE && widx < IDX_MUX_BASE + 6'h08) begin
				rdata_ff[15:0] <= mux_ff[widx[2:0]];
			end else if (widx == IDX_CAL_EN) begin
				rdata_ff[7:0] <= cal_en_ff;
			end else if (widx == IDX_STATUS) begin
				rdata_ff[6:0] <= {lp_fast, afe_power_on, state_ff, stage_ff};
			end
		end
	end

	// Writable control registers
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			power_control_ff          <= POWER_CONTROL_RST;
			ambient_comp_control_0_ff <= AMB_COMP_RST;
			cal_en_ff                 <= CAL_EN_RST;
			for (int i = 0; i < NUM_STAGES; i++) begin
				trim_ff[i] <= TRIM_RST;
				mux_ff[i]  <= MUX_RST;
			end
		end else if (wr_go) begin
			if (widx == IDX_POWER_CONTROL) begin
				power_control_ff <= (power_control_ff & ~wmask) | (avs_writedata[15:0] & wmask);
			end
			if (widx == IDX_AMB_COMP_0) begin
				ambient_comp_control_0_ff <= (ambient_comp_control_0_ff & ~wmask)
					| (avs_writedata[15:0] & wmask);
			end
			if (widx == IDX_CAL_EN && avs_byteenable[0]) begin
				cal_en_ff <= avs_writedata[7:0];
			end
			if (widx >= IDX_TRIM_BASE && widx < IDX_TRIM_BASE + 6'h08) begin
				trim_ff[widx[2:0]] <= (trim_ff[widx[2:0]] & ~wmask)
					| (avs_writedata[15:0] & wmask);
			end
			if (widx >= IDX_MUX_BASE && widx < IDX_MUX_BASE + 6'h08) begin
				mux_ff[widx[2:0]] <= (mux_ff[widx[2:0]] & ~wmask)
					| (avs_writedata[15:0] & wmask);
			end
		end
	end

	// Modulator bit crosses in from the analog side
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			mod_s1_ff <= 1'b0;
			mod_s2_ff <= 1'b0;
		end else begin
			mod_s1_ff <= mod_bit;
			mod_s2_ff <= mod_s1_ff;
		end
	end

	// Sample counts per decimation code
	always_comb begin
		case (dec_ff)
			2'b00:   samples_needed = 10'(SAMPLES_PER_DEC * 256);
			2'b01:   samples_needed = 10'(SAMPLES_PER_DEC * 128);
			default: samples_needed = 10'(SAMPLES_PER_DEC * 64);
		endcase
	end

	// Average of ones: count * (65535/3) / decimation
	assign scaled = 25'((ones_cnt_ff + {9'h000, mod_s2_ff}) * THIRD_SCALE);  // last sample
	always_comb begin
		case (dec_ff)
			2'b00:   avg_result = scaled[23:8];
			2'b01:   avg_result = scaled[22:7];
			default: avg_result = scaled[21:6];
		endcase
	end

	// 250 kHz sample strobe while converting
	assign sample_tick = (state_ff == ST_CONV) && (smp_div_ff == 8'(SAMPLE_CYC - 1));
	assign stage_done  = sample_tick && (smp_cnt_ff == samples_needed - 10'h001);
	assign seq_done    = stage_done && (stage_ff == last_ff);

	// Requested last stage clamped to eight stages
	assign last_req = power_control_ff[LAST_LSB + 3] ? 3'h7
		: power_control_ff[LAST_LSB +: 3];

	// Idle interval and sleep timeout lengths
	assign idle_cycles  = (32'(power_control_ff[IDLE_LSB +: 2]) + 32'h1)
		* IDLE_STEP_CYCLES;
	assign sleep_cycles = (32'(ambient_comp_control_0_ff[SLEEP_LSB +: 2]) + 32'h1)
		* SLEEP_STEP_CYCLES;

	// Low power stays fast while touched or during the sleep timeout
	assign lp_fast = low_power && (touch_active || hold_ff != 32'h0);

	// Start-to-start period for the current situation
	always_comb begin
		if (!low_power) begin
			target_period = 32'h0;
		end else if (proximity_active && !touch_active) begin
			target_period = PROX_CYCLES;
		end else if (lp_fast) begin
			target_period = TOUCH_CYCLES;
		end else begin
			target_period = idle_cycles;
		end
	end

	// Sleep entry timeout after touching stops
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			hold_ff <= 32'h0;
		end else if (!low_power || touch_active) begin
			hold_ff <= low_power ? sleep_cycles : 32'h0;
		end else if (hold_ff != 32'h0) begin
			hold_ff <= hold_ff - 32'h1;
		end
	end

	// Sequencer state transitions
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_OFF: begin
				if (!shutdown) begin
					nxt_state = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (shutdown) begin
					nxt_state = ST_OFF;
				end else if (period_ff >= target_period) begin
					nxt_state = ST_CONV;
				end
			end
			ST_CONV: begin
				if (shutdown) begin
					nxt_state = ST_OFF;
				end else if (seq_done) begin
					nxt_state = (target_period == 32'h0) ? ST_CONV : ST_WAIT;
				end
			end
			default: nxt_state = ST_OFF;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_ff <= ST_OFF;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Period timer counts from the start of each sequence entered from the wait state
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			period_ff <= 32'h0;
		end else if (state_ff == ST_OFF) begin
			period_ff <= 32'hFFFF_FFFF;
		end else if (state_ff == ST_WAIT && nxt_state == ST_CONV) begin
			period_ff <= 32'h0;
		end else if (period_ff != 32'hFFFF_FFFF) begin
			period_ff <= period_ff + 32'h1;
		end
	end

	// Stage stepping; settings latch at each sequence start
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			stage_ff <= 3'h0;
			last_ff  <= 3'h0;
			dec_ff   <= 2'b00;
		end else if (state_ff != ST_CONV || seq_done) begin
			stage_ff <= 3'h0;
			last_ff  <= last_req;
			dec_ff   <= power_control_ff[DEC_LSB +: 2];
		end else if (stage_done) begin
			stage_ff <= stage_ff + 3'h1;
		end
	end

	// Sample divider and ones accumulator
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			smp_div_ff  <= 8'h00;
			smp_cnt_ff  <= 10'h000;
			ones_cnt_ff <= 10'h000;
		end else if (state_ff != ST_CONV) begin
			smp_div_ff  <= 8'h00;
			smp_cnt_ff  <= 10'h000;
			ones_cnt_ff <= 10'h000;
		end else if (sample_tick) begin
			smp_div_ff <= 8'h00;
			if (stage_done) begin
				smp_cnt_ff  <= 10'h000;
				ones_cnt_ff <= 10'h000;
			end else begin
				smp_cnt_ff  <= smp_cnt_ff + 10'h001;
				ones_cnt_ff <= ones_cnt_ff + {9'h000, mod_s2_ff};
			end
		end else begin
			smp_div_ff <= smp_div_ff + 8'h01;
		end
	end

	// Result capture per stage
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < NUM_STAGES; i++) begin
				stage_result_ff[i] <= 16'h0000;
			end
			res_vld_ff   <= 1'b0;
			res_stage_ff <= 3'h0;
			res_data_ff  <= 16'h0000;
			amb_ff       <= 1'b0;
		end else begin
			res_vld_ff <= stage_done;
			amb_ff     <= stage_done && !touch_active;
			if (stage_done) begin
				stage_result_ff[stage_ff] <= avg_result;
				res_stage_ff              <= stage_ff;
				res_data_ff               <= avg_result;
			end
		end
	end

	// Differential button pairs report at most one side
	generate
		for (genvar g = 0; g < NUM_STAGES; g++) begin : g_pair
			always_ff @(posedge clk_sys or negedge rstn) begin
				if (!rstn) begin
					rpt_a_ff[g] <= 1'b0;
					rpt_b_ff[g] <= 1'b0;
				end else begin
					rpt_a_ff[g] <= pair_hit_a[g] & ~pair_hit_b[g];
					rpt_b_ff[g] <= pair_hit_b[g] & ~pair_hit_a[g];
				end
			end
		end
	endgenerate

	// Front-end drive follows the active stage
	assign afe_power_on             = (state_ff == ST_CONV);
	assign afe_sample               = sample_tick;
	assign afe_stage                = stage_ff;
	assign afe_mux_cfg              = mux_ff[stage_ff];
	assign positive_offset_trim     = trim_ff[stage_ff][POS_LSB +: 6];
	assign negative_offset_trim     = trim_ff[stage_ff][NEG_LSB +: 6];
	assign stage_calibration_enable = cal_en_ff;
	assign pair_report_a            = rpt_a_ff;
	assign pair_report_b            = rpt_b_ff;
	assign result_valid             = res_vld_ff;
	assign result_stage             = res_stage_ff;
	assign result_data              = res_data_ff;
	assign ambient_update           = amb_ff;

endmodule

/* File: test/csq_sequencer_monitor.sv */
`timescale 1ns/100ps
// Port-level checks of the conversion sequencer
module csq_monitor (
	input wire logic        clk_sys,
	input wire logic        rstn,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        afe_power_on,
	input wire logic        afe_sample,
	input wire logic [2:0]  afe_stage,
	input wire logic        touch_active,
	input wire logic [7:0]  pair_hit_a,
	input wire logic [7:0]  pair_hit_b,
	input wire logic [7:0]  pair_report_a,
	input wire logic [7:0]  pair_report_b,
	input wire logic        result_valid,
	input wire logic        ambient_update
);
	logic [7:0] gap_ff;
	logic       seen_ff;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	// Cycles since the last modulator sample within one conversion run
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			gap_ff <= 8'h00;
		else if (!afe_power_on || afe_sample)
			gap_ff <= 8'h00;
		else
			gap_ff <= gap_ff + 8'h01;
	end

	// Marks that a first sample of the run has been seen
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			seen_ff <= 1'b0;
		else
			seen_ff <= afe_power_on && (seen_ff || afe_sample);
	end

	a_wait_single: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("waitrequest held longer than one cycle");
	a_wait_first: assert property ($rose(avs_read) || $rose(avs_write) |-> avs_waitrequest)
		else $error("access answered without wait cycle");
	a_read_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
		else $error("upper read data not zero");
	a_sample_period: assert property (afe_sample && seen_ff |-> gap_ff == 8'hC7)
		else $error("sample spacing not 200 cycles");
	a_sample_powered: assert property (afe_sample |-> afe_power_on)
		else $error("sample while converter off");
	a_result_pulse: assert property (result_valid |=> !result_valid)
		else $error("result pulse longer than one cycle");
	a_ambient_with: assert property (ambient_update |-> result_valid)
		else $error("ambient update without result");
	a_ambient_touch: assert property (result_valid |-> ambient_update == !$past(touch_active))
		else $error("ambient update disagrees with touch");
	a_pair_excl: assert property (1'b1 |=> pair_report_a == $past(pair_hit_a & ~pair_hit_b)
		&& pair_report_b == $past(pair_hit_b & ~pair_hit_a))
		else $error("pair report not exclusive");
	a_stage_step: assert property ($changed(afe_stage) |->
		afe_stage == 3'h0 || afe_stage == $past(afe_stage) + 3'h1)
		else $error("stage did not step or restart");
endmodule

bind csq_sequencer csq_monitor mon_u (.clk_sys, .rstn, .avs_read, .avs_write, .avs_readdata,
	.avs_waitrequest, .afe_power_on, .afe_sample, .afe_stage, .touch_active, .pair_hit_a,
	.pair_hit_b, .pair_report_a, .pair_report_b, .result_valid, .ambient_update);

/* File: test/csq_sequencer_tb.sv */
`timescale 1ns/100ps
module csq_sequencer_tb
	import csq_pkg::*;
;
	logic        clk_sys          = 1'b0;
	logic        rstn             = 1'b0;
	logic [7:0]  avs_address      = 8'h00;
	logic        avs_read         = 1'b0;
	logic        avs_write        = 1'b0;
	logic [31:0] avs_writedata    = 32'h00000000;
	logic [3:0]  avs_byteenable   = 4'h3;
	logic        mod_bit          = 1'b1;
	logic        touch_active     = 1'b0;
	logic        proximity_active = 1'b0;
	logic [7:0]  pair_hit_a       = 8'h00;
	logic [7:0]  pair_hit_b       = 8'h00;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest, afe_power_on, afe_sample, result_valid, ambient_update;
	logic [2:0]  afe_stage, result_stage;
	logic [15:0] afe_mux_cfg, result_data, rd;
	logic [5:0]  positive_offset_trim, negative_offset_trim;
	logic [7:0]  pair_report_a, pair_report_b, stage_calibration_enable;
	logic [5:0]  ri [6] = '{IDX_POWER_CONTROL, IDX_AMB_COMP_0, IDX_TRIM_BASE, IDX_MUX_BASE,
		IDX_CAL_EN, 6'h3F};
	logic [7:0]  pa [3] = '{8'hF0, 8'hFF, 8'h5A};
	logic [7:0]  pb [3] = '{8'hCC, 8'hFF, 8'h00};
	int          num_errors = 0;
	int          cmp_count = 0;
	int          smp, cyc;

	// Free-running system clock
	always #10 clk_sys = ~clk_sys;

	csq_sequencer #(.IDLE_STEP_CYCLES(2000), .TOUCH_CYCLES(500), .PROX_CYCLES(700),
		.SLEEP_STEP_CYCLES(300)) dut_u (.clk_sys, .rstn, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .mod_bit,
		.afe_power_on, .afe_sample, .afe_stage, .afe_mux_cfg, .positive_offset_trim,
		.negative_offset_trim, .touch_active, .proximity_active, .pair_hit_a, .pair_hit_b,
		.pair_report_a, .pair_report_b, .stage_calibration_enable, .result_valid,
		.result_stage, .result_data, .ambient_update);

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp1(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: flag got %b expected %b", $time, got, exp);
		end
	endtask

	// One Avalon access, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [5:0] idx, input logic [15:0] d,
		input logic [3:0] be);
		@(posedge clk_sys);
		avs_address <= {idx, 2'b00};
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= {16'h0000, d};
		avs_byteenable <= be;
		// Wait for the answer; only the watchdog ends a hang
		do begin
			@(posedge clk_sys);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata[15:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task automatic wr(input logic [5:0] idx, input logic [15:0] d);
		bus(1'b1, idx, d, 4'h3);
	endtask

	task automatic rdc(input logic [5:0] idx, input logic [15:0] exp);
		bus(1'b0, idx, 16'h0000, 4'h3);
		cmp(rd, exp);
	endtask

	task automatic close_out();
		$display("counts: %0d comparisons, %0d mismatches", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		for (int i = 0; i < 6; i++) rdc(ri[i], 16'h0000);
		cmp(16'(stage_calibration_enable), 16'h0000);
		cmp1(afe_power_on, 1'b1);
		$display("test reset done");
		for (int m = 1; m < 4; m += 2) begin
			wr(IDX_POWER_CONTROL, m[15:0]);
			repeat (250) @(posedge clk_sys);
			cmp1(afe_power_on, 1'b0);
			rdc(IDX_STATUS, 16'h0000);
		end
		wr(IDX_RESULT_BASE, 16'h1234);
		rdc(IDX_RESULT_BASE, 16'h0000);
		wr(IDX_POWER_CONTROL, 16'h0200);
		repeat (3) @(posedge clk_sys);
		cmp1(afe_power_on, 1'b1);
		cmp(16'(afe_stage), 16'h0000);
		rdc(IDX_STATUS, 16'h0038);
		$display("test shutdown done");
		wr(IDX_AMB_COMP_0, 16'h3000);
		rdc(IDX_AMB_COMP_0, 16'h3000);
		wr(IDX_TRIM_BASE, 16'h2A15);
		wr(IDX_MUX_BASE, 16'hA5C3);
		wr(IDX_CAL_EN, 16'h00FF);
		repeat (2) @(posedge clk_sys);
		cmp(16'(positive_offset_trim), 16'h0015);
		cmp(16'(negative_offset_trim), 16'h002A);
		cmp(afe_mux_cfg, 16'hA5C3);
		cmp(16'(stage_calibration_enable), 16'h00FF);
		wr(IDX_TRIM_BASE + 6'h01, 16'h3F3F);
		bus(1'b1, IDX_TRIM_BASE + 6'h01, 16'h0000, 4'h2);
		rdc(IDX_TRIM_BASE + 6'h01, 16'h003F);
		$display("test settings done");
		for (int i = 0; i < 3; i++) begin
			@(posedge clk_sys);
			pair_hit_a <= pa[i];
			pair_hit_b <= pb[i];
			repeat (2) @(posedge clk_sys);
			cmp(16'(pair_report_a), {8'h00, pa[i] & ~pb[i]});
			cmp(16'(pair_report_b), {8'h00, pb[i] & ~pa[i]});
		end
		$display("test pairs done");
		cyc = 0;
		while (result_valid !== 1'b1 && cyc < 45000) begin
			@(posedge clk_sys);
			cyc++;
		end
		cmp(16'(result_stage), 16'h0000);
		cmp(result_data, 16'hFFFF);
		cmp1(ambient_update, 1'b1);
		mod_bit <= 1'b0;
		touch_active <= 1'b1;
		smp = 0;
		cyc = 0;
		do begin
			@(posedge clk_sys);
			cyc++;
			if (afe_sample === 1'b1) smp++;
		end while (result_valid !== 1'b1 && cyc < 45000);
		cmp(cyc[15:0], 16'h9600);
		cmp(smp[15:0], 16'h00C0);
		cmp(result_data, 16'h0000);
		cmp(16'(result_stage), 16'h0000);
		cmp1(ambient_update, 1'b0);
		cmp1(afe_power_on, 1'b1);
		rdc(IDX_RESULT_BASE, 16'h0000);
		$display("test conversion done");
		// Low power while touched, then the sleep timeout of 4 steps
		wr(IDX_POWER_CONTROL, 16'h0202);
		rdc(IDX_STATUS, 16'h0078);
		@(posedge clk_sys);
		touch_active <= 1'b0;
		repeat (1100) @(posedge clk_sys);
		rdc(IDX_STATUS, 16'h0078);
		repeat (200) @(posedge clk_sys);
		rdc(IDX_STATUS, 16'h0038);
		$display("test low power done");
		close_out();
	end

	// Watchdog just beyond two full stages
	initial begin
		#1800000;
		num_errors++;
		$display("mismatch at %0t: watchdog expired", $time);
		close_out();
	end
endmodule
